//--- hw/ufl_control.sv
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/10ps
// How it works
// [RL1] FIFO enable gates all other FIFO bits
// [RL2] Receive FIFO reset pulses, self-clearing
// [RL3] Transmit FIFO reset pulses, self-clearing
// [RL4] DMA bit selects ready pin behaviour
// [RL5] Transmit trigger 16/8/24/30, below-level or empty
// [RL6] Host sets enhanced bit before transmit trigger
// [RL7] Receive trigger 8/16/24/28
// [RL8] Auto RTS hysteresis from receive trigger code
// [RL9] Word length 5 to 8 bits
// [RL10] Stop bits: one, one-and-half, two
// [RL11] Parity enable adds and checks parity
// [RL12] Even-select chooses odd or even parity
// [RL13] Forced parity is inverse of even-select
// [RL14] Break holds serial output low
// [RL15] Divisor access unless value is 0xbf
// [RL16] Modem bits 0-2 drive low-active outputs
// [RL17] Auto flow control may drive RTS
// [RL18] Bit 3 drives second general output outside PC mode; in PC mode that output is held high
// [RL19] PC mode: bit 3 gates interrupt request
// [RL20] Bit 4 selects local loopback
// [RL21] Status top bits mirror FIFO enable
// [RL22] Transmit trigger write ignored without enhanced bit
module ufl_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pc_bus_mode,
  input wire logic [5:0] tx_fifo_count,
  input wire logic [5:0] rx_fifo_count,
  input wire logic tx_fifo_load,
  input wire logic [5:0] interrupt_id,
  input wire logic interrupt_pending,
  input wire logic tx_serial_raw,
  output logic fifo_enable,
  output logic rx_fifo_clear,
  output logic tx_fifo_clear,
  output logic dma_mode,
  output logic [5:0] tx_trigger_level,
  output logic [5:0] rx_trigger_level,
  output logic tx_interrupt_event,
  output logic rx_trigger_hit,
  output logic [3:0] char_bits,
  output logic long_stop,
  output logic half_extra_stop,
  output logic parity_enable,
  output logic parity_even,
  output logic parity_forced,
  output logic parity_forced_value,
  output logic tx_serial_out,
  output logic divisor_select,
  output logic enhanced_access,
  output logic terminal_ready_n,
  output logic request_to_send_n,
  output logic general_out1_n,
  output logic general_out2_n,
  output logic interrupt_request_out,
  output logic loopback,
  output logic tx_ready_pin_n,
  output logic rx_ready_pin_n
);

  //////////////////////////////////////////////////////////////////////////////
  logic fifo_en_reg;
  logic dma_reg;
  logic [1:0] tx_trig_code_reg;
  logic [1:0] rx_trig_code_reg;
  logic mode_s1_reg;
  logic mode_s2_reg;
  logic mode_s3_reg;
  logic pc_mode_reg;
  logic fc_wr;
  logic fc_en_wr;
  logic rd_setup;
  logic [7:0] rd_byte;
  logic [7:0] line_format_control_reg;
  logic [7:0] modem_output_control_reg;
  logic [7:0] enhanced_feature_reg;
  logic rx_clear_reg;
  logic tx_clear_reg;
  logic rts_auto_n_reg;
  logic tx_refill_over_reg;
  logic tx_below_reg;
  logic tx_empty_reg;
  logic [7:0] wbyte;
  logic wr_en;
  logic rd_en;
  logic [5:0] rts_off_level;
  logic [5:0] rts_on_level;
  logic tx_below;
  logic tx_empty;

  assign wbyte = pwdata[7:0];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign fc_wr = wr_en && paddr == ufl_pkg::UFL_ADDR_FIFO_CONTROL;
  assign fc_en_wr = fc_wr && wbyte[ufl_pkg::UFL_FC_EN]; // [RL1]
  assign rd_setup = psel && !penable && !pwrite;

  //////////////////////////////////////////////////////////////////////////////
  // The enable bit is taken on every write; the other fields only alongside it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_en_reg <= 1'b0;
    end else if (fc_wr) begin
      fifo_en_reg <= wbyte[ufl_pkg::UFL_FC_EN]; // [RL1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_reg <= 1'b0;
    end else if (fc_en_wr) begin
      dma_reg <= wbyte[ufl_pkg::UFL_FC_DMA]; // [RL4]
    end
  end

  // Without the enhanced bit a write leaves the old transmit code in place.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_trig_code_reg <= ufl_pkg::UFL_RESET_CODE;
    end else if (fc_en_wr && enhanced_feature_reg[ufl_pkg::UFL_EF_ENH]) begin // [RL22]
      tx_trig_code_reg <= wbyte[ufl_pkg::UFL_FC_TXTRIG_HI:ufl_pkg::UFL_FC_TXTRIG_LO]; // [RL5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_trig_code_reg <= ufl_pkg::UFL_RESET_CODE;
    end else if (fc_en_wr) begin
      rx_trig_code_reg <= wbyte[ufl_pkg::UFL_FC_RXTRIG_HI:ufl_pkg::UFL_FC_RXTRIG_LO]; // [RL7]
    end
  end

  // The bus-mode strap is asynchronous: three stages, taken once the last two agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_s1_reg <= 1'b0;
      mode_s2_reg <= 1'b0;
      mode_s3_reg <= 1'b0;
      pc_mode_reg <= 1'b0;
    end else begin
      mode_s1_reg <= pc_bus_mode;
      mode_s2_reg <= mode_s1_reg;
      mode_s3_reg <= mode_s2_reg;
      if (mode_s2_reg == mode_s3_reg) begin
        pc_mode_reg <= mode_s3_reg;
      end
    end
  end

  // Reset strobes last one cycle and never read back.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_clear_reg <= 1'b0;
    end else begin
      rx_clear_reg <= fc_en_wr && wbyte[ufl_pkg::UFL_FC_RXRST]; // [RL2]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_clear_reg <= 1'b0;
    end else begin
      tx_clear_reg <= fc_en_wr && wbyte[ufl_pkg::UFL_FC_TXRST]; // [RL3]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_format_control_reg <= ufl_pkg::UFL_RESET_BYTE;
    end else if (wr_en && paddr == ufl_pkg::UFL_ADDR_LINE_FORMAT_CONTROL) begin
      line_format_control_reg <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_output_control_reg <= ufl_pkg::UFL_RESET_BYTE;
    end else if (wr_en && paddr == ufl_pkg::UFL_ADDR_MODEM_OUTPUT_CONTROL) begin
      modem_output_control_reg <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enhanced_feature_reg <= ufl_pkg::UFL_RESET_BYTE;
    end else if (wr_en && paddr == ufl_pkg::UFL_ADDR_ENHANCED_FEATURE) begin
      enhanced_feature_reg <= wbyte; // [RL6]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign fifo_enable = fifo_en_reg;
  assign rx_fifo_clear = rx_clear_reg;
  assign tx_fifo_clear = tx_clear_reg;
  assign dma_mode = dma_reg; // [RL4]

  always_comb begin
    case (tx_trig_code_reg) // [RL5]
      2'h0: tx_trigger_level = ufl_pkg::UFL_TX_LVL0;
      2'h1: tx_trigger_level = ufl_pkg::UFL_TX_LVL1;
      2'h2: tx_trigger_level = ufl_pkg::UFL_TX_LVL2;
      default: tx_trigger_level = ufl_pkg::UFL_TX_LVL3;
    endcase
  end

  always_comb begin
    case (rx_trig_code_reg) // [RL7]
      2'h0: rx_trigger_level = ufl_pkg::UFL_RX_LVL0;
      2'h1: rx_trigger_level = ufl_pkg::UFL_RX_LVL1;
      2'h2: rx_trigger_level = ufl_pkg::UFL_RX_LVL2;
      default: rx_trigger_level = ufl_pkg::UFL_RX_LVL3;
    endcase
  end

  // Auto RTS thresholds follow the receive trigger code.
  always_comb begin
    case (rx_trig_code_reg) // [RL8]
      2'h0: begin
        rts_off_level = ufl_pkg::UFL_RTS_OFF0;
        rts_on_level = ufl_pkg::UFL_RTS_ON0;
      end
      2'h1: begin
        rts_off_level = ufl_pkg::UFL_RTS_OFF1;
        rts_on_level = ufl_pkg::UFL_RTS_ON1;
      end
      2'h2: begin
        rts_off_level = ufl_pkg::UFL_RTS_OFF2;
        rts_on_level = ufl_pkg::UFL_RTS_ON2;
      end
      default: begin
        rts_off_level = ufl_pkg::UFL_RTS_OFF3;
        rts_on_level = ufl_pkg::UFL_RTS_ON3;
      end
    endcase
  end

  assign rx_trigger_hit = fifo_enable && rx_fifo_count >= rx_trigger_level;

  // Transmit event: count falls below level, or FIFO empties after a shallow refill.
  assign tx_below = tx_fifo_count < tx_trigger_level;
  assign tx_empty = tx_fifo_count == ufl_pkg::UFL_LEVEL_EMPTY;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_below_reg <= 1'b1;
      tx_empty_reg <= 1'b1;
    end else begin
      tx_below_reg <= tx_below;
      tx_empty_reg <= tx_empty;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_refill_over_reg <= 1'b0;
    end else begin
      if (tx_fifo_load && tx_empty) begin
        tx_refill_over_reg <= 1'b0;
      end else if (!tx_below) begin
        tx_refill_over_reg <= 1'b1;
      end else if (tx_empty) begin
        tx_refill_over_reg <= 1'b0;
      end
    end
  end

  assign tx_interrupt_event = fifo_enable &&
    ((tx_refill_over_reg && tx_below && !tx_below_reg) ||
     (!tx_refill_over_reg && tx_empty && !tx_empty_reg)); // [RL5]

  // Automatic RTS with hysteresis; low-active, asserted after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_auto_n_reg <= 1'b0;
    end else if (rx_fifo_count >= rts_off_level) begin
      rts_auto_n_reg <= 1'b1; // [RL8]
    end else if (rx_fifo_count <= rts_on_level) begin
      rts_auto_n_reg <= 1'b0; // [RL8]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign char_bits = ufl_pkg::UFL_CHAR_BITS_MIN + {2'h0, line_format_control_reg[1:0]}; // [RL9]
  assign long_stop = line_format_control_reg[ufl_pkg::UFL_LF_STOP]; // [RL10]
  assign half_extra_stop = long_stop && line_format_control_reg[1:0] == 2'b00; // [RL10]
  assign parity_enable = line_format_control_reg[ufl_pkg::UFL_LF_PAR_EN]; // [RL11]
  assign parity_even = line_format_control_reg[ufl_pkg::UFL_LF_EVEN]; // [RL12]
  assign parity_forced = parity_enable && line_format_control_reg[ufl_pkg::UFL_LF_FORCE];
  assign parity_forced_value = !parity_even; // [RL13]
  assign tx_serial_out = line_format_control_reg[ufl_pkg::UFL_LF_BREAK] ?
                         1'b0 : tx_serial_raw; // [RL14]
  assign enhanced_access = line_format_control_reg == ufl_pkg::UFL_LF_ENH_ACCESS;
  assign divisor_select = line_format_control_reg[ufl_pkg::UFL_LF_DIV] &&
                          !enhanced_access; // [RL15]

  //////////////////////////////////////////////////////////////////////////////
  assign terminal_ready_n = !modem_output_control_reg[ufl_pkg::UFL_MO_DTR]; // [RL16]
  assign request_to_send_n = enhanced_feature_reg[ufl_pkg::UFL_EF_AUTORTS] ?
    rts_auto_n_reg : !modem_output_control_reg[ufl_pkg::UFL_MO_RTS]; // [RL16] [RL17]
  assign general_out1_n = !modem_output_control_reg[ufl_pkg::UFL_MO_OUT1]; // [RL16]
  // Second general output and the interrupt gate share one bit; the bus mode picks.
  assign general_out2_n = pc_mode_reg ? 1'b1 :
                          !modem_output_control_reg[ufl_pkg::UFL_MO_OUT2]; // [RL18]
  assign interrupt_request_out = pc_mode_reg ?
    (modem_output_control_reg[ufl_pkg::UFL_MO_OUT2] && interrupt_pending) :
    interrupt_pending; // [RL19]
  assign loopback = modem_output_control_reg[ufl_pkg::UFL_MO_LOOP]; // [RL20]

  // Ready pins: single-character mode without DMA, level-based with DMA.
  assign tx_ready_pin_n = dma_mode ? (tx_fifo_count >= ufl_pkg::UFL_FIFO_DEPTH) :
                          !tx_empty;
  assign rx_ready_pin_n = dma_mode ? !rx_trigger_hit :
                          (rx_fifo_count == ufl_pkg::UFL_LEVEL_EMPTY);

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_byte = ufl_pkg::UFL_RESET_BYTE;
    case (paddr)
      ufl_pkg::UFL_ADDR_LINE_FORMAT_CONTROL: rd_byte = line_format_control_reg;
      ufl_pkg::UFL_ADDR_MODEM_OUTPUT_CONTROL: rd_byte = modem_output_control_reg;
      ufl_pkg::UFL_ADDR_ENHANCED_FEATURE: rd_byte = enhanced_feature_reg;
      ufl_pkg::UFL_ADDR_INTERRUPT_STATUS:
        rd_byte = {{2{fifo_enable}}, interrupt_id}; // [RL21]
      ufl_pkg::UFL_ADDR_FIFO_STATUS:
        rd_byte = {rts_auto_n_reg, tx_refill_over_reg, rx_trig_code_reg, tx_trig_code_reg,
                   dma_reg, fifo_en_reg};
      ufl_pkg::UFL_ADDR_SETTINGS:
        rd_byte = {2'h0, tx_trigger_level};
      default: rd_byte = ufl_pkg::UFL_RESET_BYTE;
    endcase
  end

  // Read data is captured in the setup phase, so it leaves a flip-flop with no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= {24'h00_0000, rd_byte};
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // Writes to status offsets and any access to an unmapped offset end with an error.
  always_comb begin
    pslverr = 1'b0;
    if (wr_en) begin
      case (paddr)
        ufl_pkg::UFL_ADDR_FIFO_CONTROL, ufl_pkg::UFL_ADDR_LINE_FORMAT_CONTROL,
        ufl_pkg::UFL_ADDR_MODEM_OUTPUT_CONTROL, ufl_pkg::UFL_ADDR_ENHANCED_FEATURE:
          pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end else if (rd_en) begin
      case (paddr)
        ufl_pkg::UFL_ADDR_FIFO_CONTROL, ufl_pkg::UFL_ADDR_LINE_FORMAT_CONTROL,
        ufl_pkg::UFL_ADDR_MODEM_OUTPUT_CONTROL, ufl_pkg::UFL_ADDR_ENHANCED_FEATURE:
          pslverr = 1'b0;
        ufl_pkg::UFL_ADDR_INTERRUPT_STATUS, ufl_pkg::UFL_ADDR_FIFO_STATUS,
        ufl_pkg::UFL_ADDR_SETTINGS:
          pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end
  end

endmodule : ufl_control

//--- hw/ufl_pkg.sv
package ufl_pkg;
  // Register byte addresses on the APB bus.
  localparam logic [7:0] UFL_ADDR_FIFO_CONTROL = 8'h00;
  localparam logic [7:0] UFL_ADDR_LINE_FORMAT_CONTROL = 8'h04;
  localparam logic [7:0] UFL_ADDR_MODEM_OUTPUT_CONTROL = 8'h08;
  localparam logic [7:0] UFL_ADDR_ENHANCED_FEATURE = 8'h0c;
  localparam logic [7:0] UFL_ADDR_INTERRUPT_STATUS = 8'h10;
  localparam logic [7:0] UFL_ADDR_FIFO_STATUS = 8'h14;
  localparam logic [7:0] UFL_ADDR_SETTINGS = 8'h18;

  // fifo_control fields.
  localparam int UFL_FC_EN = 0;
  localparam int UFL_FC_RXRST = 1;
  localparam int UFL_FC_TXRST = 2;
  localparam int UFL_FC_DMA = 3;
  localparam int UFL_FC_TXTRIG_LO = 4;
  localparam int UFL_FC_RXTRIG_LO = 6;

  // line_format_control fields.
  localparam int UFL_LF_STOP = 2;
  localparam int UFL_LF_PAR_EN = 3;
  localparam int UFL_LF_EVEN = 4;
  localparam int UFL_LF_FORCE = 5;
  localparam int UFL_LF_BREAK = 6;
  localparam int UFL_LF_DIV = 7;
  localparam logic [7:0] UFL_LF_ENH_ACCESS = 8'hbf;

  // modem_output_control fields.
  localparam int UFL_MO_DTR = 0;
  localparam int UFL_MO_RTS = 1;
  localparam int UFL_MO_OUT1 = 2;
  localparam int UFL_MO_OUT2 = 3;
  localparam int UFL_MO_LOOP = 4;

  // enhanced_feature_register fields.
  localparam int UFL_EF_ENH = 4;
  localparam int UFL_EF_AUTORTS = 6;

  localparam logic [7:0] UFL_RESET_BYTE = 8'h00;
  localparam logic [5:0] UFL_FIFO_DEPTH = 6'h20;
  localparam logic [1:0] UFL_RESET_CODE = 2'h0;
  localparam int UFL_FC_TXTRIG_HI = 5;
  localparam int UFL_FC_RXTRIG_HI = 7;
  localparam logic [5:0] UFL_LEVEL_EMPTY = 6'h00;
  localparam logic [3:0] UFL_CHAR_BITS_MIN = 4'h5;

  // Trigger and flow-control levels, one per two-bit code.
  localparam logic [5:0] UFL_TX_LVL0 = 6'h10;
  localparam logic [5:0] UFL_TX_LVL1 = 6'h08;
  localparam logic [5:0] UFL_TX_LVL2 = 6'h18;
  localparam logic [5:0] UFL_TX_LVL3 = 6'h1e;
  localparam logic [5:0] UFL_RX_LVL0 = 6'h08;
  localparam logic [5:0] UFL_RX_LVL1 = 6'h10;
  localparam logic [5:0] UFL_RX_LVL2 = 6'h18;
  localparam logic [5:0] UFL_RX_LVL3 = 6'h1c;
  localparam logic [5:0] UFL_RTS_OFF0 = 6'h10;
  localparam logic [5:0] UFL_RTS_OFF1 = 6'h18;
  localparam logic [5:0] UFL_RTS_OFF2 = 6'h1c;
  localparam logic [5:0] UFL_RTS_OFF3 = 6'h1c;
  localparam logic [5:0] UFL_RTS_ON0 = 6'h00;
  localparam logic [5:0] UFL_RTS_ON1 = 6'h08;
  localparam logic [5:0] UFL_RTS_ON2 = 6'h10;
  localparam logic [5:0] UFL_RTS_ON3 = 6'h18;
endpackage : ufl_pkg

//--- tb/ufl_control_sva.sv
`timescale 1ns/10ps
module ufl_control_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic tx_serial_raw,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic fifo_enable,
  input wire logic rx_fifo_clear,
  input wire logic tx_fifo_clear,
  input wire logic tx_serial_out,
  input wire logic divisor_select,
  input wire logic terminal_ready_n,
  input wire logic [3:0] char_bits
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence wr_at(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  sequence fc_wr;
    wr_at(ufl_pkg::UFL_ADDR_FIFO_CONTROL);
  endsequence
  sequence lf_wr;
    wr_at(ufl_pkg::UFL_ADDR_LINE_FORMAT_CONTROL);
  endsequence
  fifo_en_a: assert property (fc_wr |=> fifo_enable == $past(pwdata[0]))
    else $error("fifo enable wrong");
  rx_clear_a: assert property (fc_wr ##0 pwdata[1:0] == 2'b11 |=> rx_fifo_clear ##1 !rx_fifo_clear)
    else $error("rx clear pulse wrong");
  tx_clear_a: assert property (fc_wr ##0 pwdata[2] && pwdata[0] |=> tx_fifo_clear ##1 !tx_fifo_clear)
    else $error("tx clear pulse wrong");
  word_len_a: assert property (lf_wr |=> char_bits == 4'h5 + $past(pwdata[1:0]))
    else $error("word length wrong");
  break_out_a: assert property (lf_wr |=> tx_serial_out == ($past(pwdata[6]) ? 1'b0 : tx_serial_raw))
    else $error("break output wrong");
  div_sel_a: assert property (lf_wr |=> divisor_select == ($past(pwdata[7]) && $past(pwdata[7:0]) != 8'hbf))
    else $error("divisor select wrong");
  dtr_out_a: assert property (wr_at(ufl_pkg::UFL_ADDR_MODEM_OUTPUT_CONTROL) |=> terminal_ready_n == !$past(pwdata[0]))
    else $error("terminal ready wrong");
  isr_top_a: assert property (psel && penable && !pwrite && paddr == ufl_pkg::UFL_ADDR_INTERRUPT_STATUS |-> prdata[7:6] == {2{fifo_enable}})
    else $error("status top bits wrong");
endmodule : ufl_control_sva
bind ufl_control ufl_control_sva chk_u (.*);

//--- tb/ufl_fifo_model.sv
`timescale 1ns/10ps
module ufl_fifo_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_fifo_clear,
  input wire logic tx_fifo_clear,
  input wire logic fill,
  output logic [5:0] tx_fifo_count,
  output logic [5:0] rx_fifo_count,
  output logic tx_fifo_load,
  output logic tx_serial_raw
);
  // Levels rise while fill is high, stopping at 32, and drop to zero on a clear pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_fifo_count <= 6'h00;
      tx_fifo_count <= 6'h00;
      tx_fifo_load <= 1'b0;
      tx_serial_raw <= 1'b1;
    end else begin
      tx_serial_raw <= ~tx_serial_raw;
      tx_fifo_load <= fill;
      if (rx_fifo_clear) rx_fifo_count <= 6'h00;
      else if (fill && rx_fifo_count < 6'h20) rx_fifo_count <= rx_fifo_count + 6'h01;
      if (tx_fifo_clear) tx_fifo_count <= 6'h00;
      else if (fill && tx_fifo_count < 6'h20) tx_fifo_count <= tx_fifo_count + 6'h01;
    end
  end
endmodule : ufl_fifo_model

//--- tb/uart_fifo_line_modem_control_bench.sv
`timescale 1ns/10ps
module uart_fifo_line_modem_control_bench;
  localparam logic [7:0] FC = ufl_pkg::UFL_ADDR_FIFO_CONTROL;
  localparam logic [7:0] LF = ufl_pkg::UFL_ADDR_LINE_FORMAT_CONTROL;
  localparam logic [7:0] MO = ufl_pkg::UFL_ADDR_MODEM_OUTPUT_CONTROL;
  localparam logic [7:0] EF = ufl_pkg::UFL_ADDR_ENHANCED_FEATURE;
  localparam logic [7:0] IS = ufl_pkg::UFL_ADDR_INTERRUPT_STATUS;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pc_bus_mode = 0;
  logic interrupt_pending = 0, fill = 0, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [5:0] interrupt_id = 0, tx_fifo_count, rx_fifo_count, tx_trigger_level, rx_trigger_level;
  logic [3:0] char_bits;
  logic pready, pslverr, tx_fifo_load, tx_serial_raw, fifo_enable, rx_fifo_clear, tx_fifo_clear;
  logic dma_mode, tx_interrupt_event, rx_trigger_hit, long_stop, half_extra_stop, parity_enable;
  logic parity_even, parity_forced, parity_forced_value, tx_serial_out, divisor_select;
  logic enhanced_access, terminal_ready_n, request_to_send_n, general_out1_n, general_out2_n;
  logic interrupt_request_out, loopback, tx_ready_pin_n, rx_ready_pin_n;
  logic [5:0] txl [4] = '{6'h10, 6'h08, 6'h18, 6'h1e};
  logic [5:0] rxl [4] = '{6'h08, 6'h10, 6'h18, 6'h1c};
  int err_total = 0, checked = 0, cyc = 0;
  ufl_control dut_u (.*);
  ufl_fifo_model far_u (.*);
  initial forever #2.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task summarize;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task xf(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(negedge pclk);
  endtask : xf
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    chk({fifo_enable, char_bits, terminal_ready_n, general_out1_n}, 7'h17);
    xf(0, LF, 0); chk(rd, 0);
    xf(1, FC, 8'hfe); chk({fifo_enable, dma_mode, rx_trigger_level, tx_fifo_clear}, 9'h010);
    xf(1, FC, 8'hf9); chk({dma_mode, tx_trigger_level, rx_trigger_level}, 13'h141c);
    xf(0, IS, 0); chk(rd[7:6], 2'h3);
    xf(1, EF, 8'h10);
    for (int i = 0; i < 4; i++) begin
      xf(1, FC, {i[1:0], i[1:0], 4'h1});
      chk({dma_mode, tx_trigger_level, rx_trigger_level}, {1'b0, txl[i], rxl[i]});
    end
    @(posedge pclk);
    fill <= 1;
    repeat (4) @(posedge pclk);
    fill <= 0;
    xf(1, FC, 8'h03); chk({rx_fifo_clear, tx_fifo_clear}, 2'h2);
    @(negedge pclk); chk({rx_fifo_count == 0, tx_fifo_count != 0, rx_fifo_clear}, 3'h6);
    xf(1, FC, 8'h05); chk({rx_fifo_clear, tx_fifo_clear}, 2'h1);
    xf(1, FC, 8'h04); chk({fifo_enable, tx_fifo_clear}, 2'h0);
    xf(0, IS, 0); chk(rd[7:6], 2'h0);
    for (int i = 0; i < 4; i++) begin
      xf(1, LF, {2'h0, i[1:0], 2'h3, i[1:0]});
      chk(char_bits, 4'h5 + i[3:0]);
      chk({long_stop | half_extra_stop, half_extra_stop}, {1'b1, i == 0});
      chk({parity_enable, parity_even, parity_forced}, {1'b1, i[0], i[1]});
      if (i[1]) chk(parity_forced_value, !i[0]);
    end
    xf(1, LF, 8'h00); chk(parity_enable, 0);
    xf(1, LF, 8'h40);
    repeat (3) begin
      chk(tx_serial_out, 0);
      @(negedge pclk);
    end
    xf(1, LF, 8'h00);
    repeat (2) begin
      chk(tx_serial_out, tx_serial_raw);
      @(negedge pclk);
    end
    xf(1, LF, 8'h80); chk(divisor_select, 1);
    xf(1, LF, 8'hbf); chk({divisor_select, enhanced_access}, 2'h1);
    xf(1, MO, 8'h1f); chk({terminal_ready_n, request_to_send_n, general_out1_n}, 0);
    chk({general_out2_n, loopback}, 2'h1);
    xf(0, MO, 0); chk(rd, 8'h1f);
    @(posedge pclk);
    pc_bus_mode <= 1;
    interrupt_pending <= 1;
    repeat (5) @(negedge pclk);
    chk({general_out2_n, interrupt_request_out}, 2'h3);
    xf(1, MO, 8'h00); chk({general_out2_n, interrupt_request_out, loopback}, 3'h4);
    xf(0, 8'h1c, 0); chk(er, 1);
    xf(1, EF, 8'h50);
    xf(1, FC, 8'h01);
    xf(1, MO, 8'h02);
    @(posedge pclk);
    fill <= 1;
    repeat (17) @(posedge pclk);
    fill <= 0;
    @(negedge pclk); chk(request_to_send_n, 1);
    chk({rx_trigger_hit, rx_ready_pin_n, tx_ready_pin_n}, 3'h5);
    xf(1, FC, 8'h03);
    repeat (2) @(negedge pclk);
    chk(request_to_send_n, 0);
    xf(1, FC, 8'h05);
    @(negedge pclk); chk(tx_interrupt_event, 1);
    @(negedge pclk); chk(tx_interrupt_event, 0);
    summarize();
  end
endmodule : uart_fifo_line_modem_control_bench
